/* File: fault_auto_restart.sv */
// Automatic fault restart supervisor
`timescale 1ns/1ps
`default_nettype none

module fault_auto_restart #(
    parameter longint unsigned CLEAN_RUN_CYCLES = restart_pkg::CLEAN_RUN_CYC,
    parameter int unsigned     TENTH_CYCLES     = restart_pkg::TENTH_SEC_CYC
) (
    input  wire logic                                 CLOCK,
    input  wire logic                                 RST_N,
    input  wire restart_pkg::fault_vec_t              FAULT_LATCHED,
    input  wire logic                                 MANUAL_RESET,
    input  wire restart_pkg::restart_cfg_t            CFG,
    input  wire logic [restart_pkg::NUM_DOUT*6-1:0]   DOUT_FUNC_SEL,
    input  wire logic                                 DIAG_DONE,
    input  wire logic                                 DIAG_PASS,
    input  wire logic                                 SEARCH_DONE,
    output logic                                      DIAG_START,
    output logic                                      SEARCH_START,
    output logic                                      FAULT_OUT,
    output logic                                      RESTART_LOCKED,
    output logic [3:0]                                RESTART_COUNT,
    output logic [restart_pkg::NUM_DOUT-1:0]          DOUT_RESTART
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    restart_pkg::fault_vec_t f_s1_q, f_s2_q;
    logic [3:0] c_s1_q, c_s2_q;      // manual reset, diag done/pass, search done
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            f_s1_q <= '0;
            f_s2_q <= '0;
            c_s1_q <= '0;
            c_s2_q <= '0;
        end else begin
            f_s1_q <= FAULT_LATCHED;
            f_s2_q <= f_s1_q;
            c_s1_q <= {MANUAL_RESET, DIAG_DONE, DIAG_PASS, SEARCH_DONE};
            c_s2_q <= c_s1_q;
        end
    end
    logic man_rst, diag_done, diag_pass, search_done;
    assign man_rst     = c_s2_q[3];
    assign diag_done   = c_s2_q[2];
    assign diag_pass   = c_s2_q[1];
    assign search_done = c_s2_q[0];

    // ----------------------------------------------------------------
    // Eligibility
    // ----------------------------------------------------------------
    logic uv_ok, any_fault, ineligible;
    restart_pkg::fault_vec_t f;
    assign f     = f_s2_q;
    assign uv_ok = (CFG.power_loss_ride_through_sel == restart_pkg::RIDE_THRU_SEL1) ||
                   (CFG.power_loss_ride_through_sel == restart_pkg::RIDE_THRU_SEL2);
    assign any_fault  = |f;
    assign ineligible = f.other_fault || (f.dc_bus_undervoltage && !uv_ok);

    // Limit clamped to legal range
    logic [3:0] limit;
    assign limit = (CFG.restart_limit > restart_pkg::LIMIT_MAX) ? restart_pkg::LIMIT_MAX
                                                                : CFG.restart_limit;
    logic [12:0] ivl;
    assign ivl = (CFG.retry_interval_time < restart_pkg::INTERVAL_MIN) ? restart_pkg::INTERVAL_MIN :
                 (CFG.retry_interval_time > restart_pkg::INTERVAL_MAX) ? restart_pkg::INTERVAL_MAX :
                 CFG.retry_interval_time;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    restart_pkg::state_t st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [31:0] tick_q, tick_d;
    logic [12:0] tenth_q, tenth_d;
    logic [37:0] clean_q, clean_d;
    logic        ds_q, ds_d, ss_q, ss_d, fo_q, fo_d, lk_q, lk_d;
    logic [restart_pkg::NUM_DOUT-1:0] dr_q, dr_d;
    logic        retrying;

    // Next-state and counter logic
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        tick_d  = tick_q;
        tenth_d = tenth_q;
        clean_d = clean_q;
        ds_d    = 1'b0;
        ss_d    = 1'b0;
        case (st_q)
            restart_pkg::ST_IDLE: begin
                if (any_fault) begin
                    if (ineligible || cnt_q >= limit) begin
                        st_d = restart_pkg::ST_LOCK;
                    end else if (CFG.restart_count_mode) begin
                        st_d    = restart_pkg::ST_WAIT;
                        tick_d  = '0;
                        tenth_d = '0;
                    end else begin
                        st_d = restart_pkg::ST_DIAG;
                        ds_d = 1'b1;
                    end
                end
            end
            restart_pkg::ST_WAIT: begin
                if (tick_q >= 32'(TENTH_CYCLES - 1)) begin
                    tick_d  = '0;
                    tenth_d = 13'(tenth_q + 13'h0001);
                end else begin
                    tick_d = 32'(tick_q + 32'h0000_0001);
                end
                if (tenth_q >= ivl) begin
                    st_d  = restart_pkg::ST_DIAG;
                    ds_d  = 1'b1;
                    cnt_d = (cnt_q < restart_pkg::LIMIT_MAX) ? 4'(cnt_q + 4'h1) : cnt_q;
                end
            end
            restart_pkg::ST_DIAG: begin
                if (diag_done) begin
                    if (diag_pass && !any_fault) begin
                        st_d = restart_pkg::ST_SEARCH;
                        ss_d = 1'b1;
                    end else if (!CFG.restart_count_mode) begin
                        ds_d = 1'b1;                                      // Failed check, retry at once
                    end else if (cnt_q >= limit) begin
                        st_d = restart_pkg::ST_LOCK;                      // Attempts used up
                    end else begin
                        st_d    = restart_pkg::ST_WAIT;                   // Next attempt after interval
                        tick_d  = '0;
                        tenth_d = '0;
                    end
                end
            end
            restart_pkg::ST_SEARCH: begin
                if (any_fault) begin
                    st_d = restart_pkg::ST_IDLE;
                end else if (search_done) begin
                    st_d    = restart_pkg::ST_RUN;
                    clean_d = '0;
                    if (!CFG.restart_count_mode && cnt_q < restart_pkg::LIMIT_MAX) begin
                        cnt_d = 4'(cnt_q + 4'h1);
                    end
                end
            end
            restart_pkg::ST_RUN: begin
                if (any_fault) begin
                    st_d = restart_pkg::ST_IDLE;
                end else if (clean_q >= 38'(CLEAN_RUN_CYCLES - 1)) begin
                    cnt_d = '0;
                    st_d  = restart_pkg::ST_IDLE;
                end else begin
                    clean_d = 38'(clean_q + 38'h1);
                end
            end
            restart_pkg::ST_LOCK: begin
                st_d = restart_pkg::ST_LOCK;
            end
            default: st_d = restart_pkg::ST_IDLE;
        endcase
        if (man_rst) begin
            st_d  = restart_pkg::ST_IDLE;
            cnt_d = '0;
        end
    end

    // Outputs derived from next state
    assign retrying = (st_d == restart_pkg::ST_WAIT) || (st_d == restart_pkg::ST_DIAG) ||
                      (st_d == restart_pkg::ST_SEARCH);
    always_comb begin
        lk_d = (st_d == restart_pkg::ST_LOCK);
        fo_d = lk_d || (retrying && CFG.retry_fault_output_sel);
        for (int i = 0; i < restart_pkg::NUM_DOUT; i++) begin
            dr_d[i] = retrying && (DOUT_FUNC_SEL[i*6 +: 6] == restart_pkg::RESTART_OUT_CODE);
        end
    end

    // State registers; power-on reset clears the counter
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_q    <= restart_pkg::ST_IDLE;
            cnt_q   <= '0;
            tick_q  <= '0;
            tenth_q <= '0;
            clean_q <= '0;
            ds_q    <= 1'b0;
            ss_q    <= 1'b0;
            fo_q    <= 1'b0;
            lk_q    <= 1'b0;
            dr_q    <= '0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            tick_q  <= tick_d;
            tenth_q <= tenth_d;
            clean_q <= clean_d;
            ds_q    <= ds_d;
            ss_q    <= ss_d;
            fo_q    <= fo_d;
            lk_q    <= lk_d;
            dr_q    <= dr_d;
        end
    end

    assign DIAG_START     = ds_q;
    assign SEARCH_START   = ss_q;
    assign FAULT_OUT      = fo_q;
    assign RESTART_LOCKED = lk_q;
    assign RESTART_COUNT  = cnt_q;
    assign DOUT_RESTART   = dr_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    counter_cap_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        cnt_q <= restart_pkg::LIMIT_MAX) else $error("restart counter past limit");
    manual_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        man_rst |=> cnt_q == 4'h0 && st_q == restart_pkg::ST_IDLE)
        else $error("manual reset did not clear");
    lock_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_LOCK && !man_rst) |=> st_q == restart_pkg::ST_LOCK)
        else $error("lock left without reset");
    zero_limit_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_IDLE && any_fault && limit == 4'h0 && !man_rst) |=> st_q == restart_pkg::ST_LOCK)
        else $error("restart with zero limit");
    uv_block_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_IDLE && f.dc_bus_undervoltage && !uv_ok && !man_rst)
        |=> st_q == restart_pkg::ST_LOCK)
        else $error("undervoltage restart without ride-through");
    other_block_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_IDLE && f.other_fault && !man_rst) |=> st_q == restart_pkg::ST_LOCK)
        else $error("ineligible fault restarted");
    diag_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        SEARCH_START |-> $past(st_q) == restart_pkg::ST_DIAG && $past(diag_done) && $past(diag_pass))
        else $error("search without passed check");
    mode0_direct_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_IDLE && any_fault && !ineligible && cnt_q < limit &&
         !CFG.restart_count_mode && !man_rst)
        |=> st_q == restart_pkg::ST_DIAG && DIAG_START) else $error("mode 0 did not retry at once");
    diag_retry_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_DIAG && diag_done && !(diag_pass && !any_fault) &&
         !CFG.restart_count_mode && !man_rst)
        |=> st_q == restart_pkg::ST_DIAG && DIAG_START) else $error("no retry after failed check");
    mode1_count_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_WAIT && st_d == restart_pkg::ST_DIAG && cnt_q < restart_pkg::LIMIT_MAX && !man_rst)
        |=> cnt_q == $past(cnt_q) + 4'h1) else $error("attempt not counted");
    wait_interval_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_WAIT && tenth_q < ivl && !man_rst) |=> st_q == restart_pkg::ST_WAIT)
        else $error("attempt before interval");
    fault_sel_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_DIAG && st_d == restart_pkg::ST_DIAG)
        |=> FAULT_OUT == $past(CFG.retry_fault_output_sel))
        else $error("fault output wrong while retrying");
    restart_ind_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_LOCK) |-> DOUT_RESTART == '0) else $error("indication while locked");
    clean_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_RUN && !any_fault && !man_rst && clean_q >= 38'(CLEAN_RUN_CYCLES - 1))
        |=> cnt_q == 4'h0) else $error("counter not cleared after clean run");

    // Main scenarios
    retry_pass_c: cover property (@(posedge CLOCK) disable iff (!RST_N)
        st_q == restart_pkg::ST_SEARCH ##1 st_q == restart_pkg::ST_RUN);
    lock_c:       cover property (@(posedge CLOCK) disable iff (!RST_N)
        st_q == restart_pkg::ST_IDLE ##1 st_q == restart_pkg::ST_LOCK);
    wait_c:       cover property (@(posedge CLOCK) disable iff (!RST_N)
        st_q == restart_pkg::ST_WAIT ##1 st_q == restart_pkg::ST_DIAG);
    retry_fail_c: cover property (@(posedge CLOCK) disable iff (!RST_N)
        (st_q == restart_pkg::ST_DIAG && diag_done && !diag_pass) ##1 DIAG_START);

endmodule : fault_auto_restart

`default_nettype wire

/* File: fault_auto_restart_tb_top.sv */
// Self-checking testbench for the automatic fault restart supervisor
`timescale 1ns/1ps
`default_nettype none
module fault_auto_restart_tb_top;
    localparam int unsigned TENTH = 4;
    logic                              CLOCK, RST_N, MANUAL_RESET, DIAG_DONE, DIAG_PASS, SEARCH_DONE;
    restart_pkg::fault_vec_t           FAULT_LATCHED;
    restart_pkg::restart_cfg_t         CFG;
    logic [restart_pkg::NUM_DOUT*6-1:0] DOUT_FUNC_SEL;
    logic                              DIAG_START, SEARCH_START, FAULT_OUT, RESTART_LOCKED;
    logic [3:0]                        RESTART_COUNT, lag;
    logic [2:0]                        DOUT_RESTART;
    logic                              pass_en;
    int                                fails = 0;
    int                                compares = 0;
    int                                cnt = 0;

    fault_auto_restart #(.CLEAN_RUN_CYCLES(200), .TENTH_CYCLES(TENTH)) i_fault_auto_restart (
        .CLOCK(CLOCK), .RST_N(RST_N), .FAULT_LATCHED(FAULT_LATCHED), .MANUAL_RESET(MANUAL_RESET),
        .CFG(CFG), .DOUT_FUNC_SEL(DOUT_FUNC_SEL), .DIAG_DONE(DIAG_DONE), .DIAG_PASS(DIAG_PASS),
        .SEARCH_DONE(SEARCH_DONE), .DIAG_START(DIAG_START), .SEARCH_START(SEARCH_START),
        .FAULT_OUT(FAULT_OUT), .RESTART_LOCKED(RESTART_LOCKED), .RESTART_COUNT(RESTART_COUNT),
        .DOUT_RESTART(DOUT_RESTART));
    run_seq_model i_run_seq_model (.CLOCK(CLOCK), .diag_start(DIAG_START), .search_start(SEARCH_START),
        .pass_en(pass_en), .lag(lag), .diag_done(DIAG_DONE), .diag_pass(DIAG_PASS), .search_done(SEARCH_DONE));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask : step
    function automatic logic eligible(input restart_pkg::fault_vec_t f);
        logic uv_ok;
        uv_ok = (CFG.power_loss_ride_through_sel == restart_pkg::RIDE_THRU_SEL1) ||
                (CFG.power_loss_ride_through_sel == restart_pkg::RIDE_THRU_SEL2);
        return !f.other_fault && (uv_ok || !f.dc_bus_undervoltage);
    endfunction : eligible
    task automatic manual();
        MANUAL_RESET = 1'b1;
        step(4);
        MANUAL_RESET = 1'b0;
        step(4);
        cnt = 0;
        check(RESTART_COUNT, 0, "count after manual reset");
        check({RESTART_LOCKED, FAULT_OUT}, 0, "lock after manual reset");
    endtask : manual
    // Setup never describes a hoist application
    task automatic set_cfg(input int lim, input int md, input int sel, input int ivl, input int rt);
        CFG = '{4'(lim), 1'(sel), 13'(ivl), 1'(md), 2'(rt)};
    endtask : set_cfg
    // One fault with its full expected outcome; bad = failing self-checks first
    task automatic fault_event(input restart_pkg::fault_vec_t f, input int bad);
        int n;
        int ivl;
        logic lk;
        logic s;
        lk = !eligible(f) || cnt >= ((CFG.restart_limit > 10) ? 10 : int'(CFG.restart_limit));
        ivl = (CFG.retry_interval_time < 5) ? 5 : int'(CFG.retry_interval_time);
        lag = 4'($urandom_range(9, 2));
        pass_en = (bad == 0);
        FAULT_LATCHED = f;
        n = 0;
        do begin step(1); n++; end while (DIAG_START !== 1'b1 && RESTART_LOCKED !== 1'b1 && n < 300);
        check(RESTART_LOCKED, lk, "lock decision");
        FAULT_LATCHED = '0;
        if (lk) begin
            check(FAULT_OUT, 1, "fault output when locked");
            check(RESTART_COUNT, cnt, "count held at limit");
            step(20);
            check(RESTART_LOCKED, 1, "lock holds without reset");
            manual();
            return;
        end
        if (CFG.restart_count_mode) begin
            check(n >= ivl * TENTH && n <= ivl * TENTH + 8, 1, "retry interval");
            cnt++;
        end else check(n <= 6, 1, "retry without interval");
        check(FAULT_OUT, CFG.retry_fault_output_sel, "fault output while retrying");
        check(DOUT_RESTART, 3'h5, "restart indication");
        check(RESTART_COUNT, cnt, "count at attempt");
        s = 1'b0;
        repeat (bad) begin
            n = 0;
            do begin step(1); n++; s |= (SEARCH_START === 1'b1); end while (DIAG_START !== 1'b1 && n < 60);
            check(n < 60, 1, "new self-check after failure");
        end
        check(s, 0, "no speed search after failed self-check");
        check(RESTART_COUNT, cnt, "failed self-check uncounted");
        pass_en = 1'b1;
        n = 0;
        do begin step(1); n++; s |= (SEARCH_START === 1'b1); end while (DOUT_RESTART !== 3'h0 && n < 200);
        check(s, 1, "restart through speed search");
        if (!CFG.restart_count_mode) cnt++;
        check(RESTART_COUNT, cnt, "count after restart");
        check(FAULT_OUT, 0, "fault output after restart");
    endtask : fault_event
    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(72));
        RST_N = 1'b0;
        MANUAL_RESET = 1'b0;
        FAULT_LATCHED = '0;
        pass_en = 1'b1;
        lag = 4'h2;
        DOUT_FUNC_SEL = {6'h1E, 6'h0E, 6'h1E};
        set_cfg(0, 0, 0, 100, 0);
        repeat (6) @(posedge CLOCK);
        #1;
        RST_N = 1'b1;
        step(2);
        fault_event(14'h2000, 0);
        set_cfg(3, 0, 1, 100, 1);
        fault_event(14'h0002, 1);
        fault_event(14'h0800, 2);
        step(140);
        check(RESTART_COUNT, 2, "count before clean run ends");
        step(80);
        check(RESTART_COUNT, 0, "count after clean run");
        cnt = 0;
        set_cfg(1, 1, 0, 0, 3);
        fault_event(14'h0004, 0);
        fault_event(14'h0010, 0);
        fault_event(14'h0002, 0);
        set_cfg(4, 0, 0, 5, 0);
        fault_event(14'h0010, 0);
        RST_N = 1'b0;
        step(3);
        check({RESTART_COUNT, RESTART_LOCKED, FAULT_OUT, DOUT_RESTART}, 0, "power cycle");
        RST_N = 1'b1;
        cnt = 0;
        step(3);
        for (int i = 0; i < 36; i++) begin
            if (i % 6 == 0) begin
                manual();
                set_cfg($urandom_range(10, 0), $urandom_range(1, 0), $urandom_range(1, 0),
                        $urandom_range(12, 0), $urandom_range(3, 0));
            end
            fault_event(restart_pkg::fault_vec_t'(14'h0001 << $urandom_range(13, 0)), 0);
        end
        stop_test();
    end
    initial begin
        #400_000;
        fails++;
        stop_test();
    end
endmodule : fault_auto_restart_tb_top
`default_nettype wire

/* File: restart_pkg.sv */
// Package: constants and types for the automatic fault restart supervisor
package restart_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned CLEAN_RUN_MIN    = 10;                 // Minutes of clean run
    localparam longint unsigned CLEAN_RUN_CYC = 64'(CLEAN_RUN_MIN) * 64'd60 * 64'(CLK_HZ);
    localparam int unsigned TENTH_SEC_MS     = 100;                // Interval unit, ms
    localparam int unsigned TENTH_SEC_CYC    = TENTH_SEC_MS * (CLK_HZ / 1000);
    localparam logic [12:0] INTERVAL_DEFAULT = 13'h0064;           // 10.0 s in 0.1 s units
    localparam logic [12:0] INTERVAL_MIN     = 13'h0005;           // 0.5 s
    localparam logic [12:0] INTERVAL_MAX     = 13'h1770;           // 600.0 s

    // ----------------------------------------------------------------
    // Settings
    // ----------------------------------------------------------------
    localparam logic [3:0] LIMIT_MAX        = 4'hA;
    localparam logic [3:0] LIMIT_DEFAULT    = 4'h0;
    localparam logic [1:0] RIDE_THRU_SEL1   = 2'h1;
    localparam logic [1:0] RIDE_THRU_SEL2   = 2'h2;
    localparam logic [5:0] RESTART_OUT_CODE = 6'h1E;
    localparam int unsigned NUM_DOUT        = 3;

    // Latched fault causes
    typedef struct packed {
        logic ground_fault;
        logic output_open_phase;
        logic overcurrent_fault;
        logic drive_overheat;
        logic motor_overload;
        logic drive_overload;
        logic overtorque_one;
        logic overtorque_two;
        logic dc_bus_high_voltage_fault;
        logic input_phase_loss;
        logic braking_resistor_fault;
        logic braking_transistor_fault;
        logic dc_bus_undervoltage;
        logic other_fault;
    } fault_vec_t;

    // Software settings
    typedef struct packed {
        logic [3:0]  restart_limit;
        logic        retry_fault_output_sel;
        logic [12:0] retry_interval_time;
        logic        restart_count_mode;
        logic [1:0]  power_loss_ride_through_sel;
    } restart_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WAIT   = 3'b001,
        ST_DIAG   = 3'b010,
        ST_SEARCH = 3'b011,
        ST_RUN    = 3'b100,
        ST_LOCK   = 3'b101
    } state_t;

endpackage : restart_pkg

/* File: run_seq_model.sv */
// Run sequencer model answering self-check and speed search requests
`timescale 1ns/1ps
`default_nettype none
module run_seq_model (
    input  wire logic       CLOCK,
    input  wire logic       diag_start,
    input  wire logic       search_start,
    input  wire logic       pass_en,
    input  wire logic [3:0] lag,
    output logic            diag_done,
    output logic            diag_pass,
    output logic            search_done
);
    int dcnt = -1;
    int scnt = -1;
    initial begin
        diag_done = 1'b0;
        diag_pass = 1'b0;
        search_done = 1'b0;
    end
    // One-cycle done levels after a delay; pass toggles while unqualified
    always @(posedge CLOCK) begin
        #1;
        diag_done = (dcnt == 0);
        diag_pass = (dcnt == 0) ? pass_en : ~diag_pass;
        search_done = (scnt == 0);
        dcnt = diag_start ? int'(lag) : ((dcnt >= 0) ? dcnt - 1 : -1);
        scnt = search_start ? int'(lag) : ((scnt >= 0) ? scnt - 1 : -1);
    end
endmodule : run_seq_model
`default_nettype wire
